/* File: sim/pvm_adv_model.sv */
// Advanced register set behind the indirect port.
// Assumes a combinational read of the selected index.
`timescale 1ns/10ps
`default_nettype none
module pvm_adv_model (
	input wire logic [6:0] adv_index,
	output logic [15:0] adv_rdata
);
	// Distinct word per index
	assign adv_rdata = {9'h14A, adv_index};
endmodule
`default_nettype wire

/* File: sim/pvm_regs_sva.sv */
// Port checker for the vendor mode register bank.
// Assumes it is bound onto pvm_regs.
`timescale 1ns/10ps
`default_nettype none
module pvm_regs_sva
	import pvm_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic [1:0] address_strap,
	input wire logic mac_clock_slow_select,
	input wire logic tenbase_polarity_flag,
	input wire logic auto_xover_disable,
	input wire logic auto_xover_pinout,
	input wire logic [15:0] adv_rdata,
	input wire logic [6:0] adv_index,
	input wire logic [4:0] station_address,
	input wire logic [1:0] tx_fifo_depth_sel,
	input wire logic pinout_x01,
	input wire logic pinout_x23
);
	logic live_q;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// Strap cycle excluded from writes
	always_ff @(posedge clock) begin
		live_q <= !srst;
	end
	wire logic wr_ok = reg_wr && live_q;
	AST_MCLK: assert property (reg_addr == PVM_OFF_SPECIAL |-> reg_rdata[6] == mac_clock_slow_select)
		else $error("clock rate bit wrong");
	AST_POL: assert property (reg_addr == PVM_OFF_INDICATE |-> reg_rdata[4] == tenbase_polarity_flag)
		else $error("polarity bit wrong");
	AST_XAUTO: assert property (!auto_xover_disable |-> pinout_x01 == auto_xover_pinout && pinout_x23 == auto_xover_pinout)
		else $error("automatic pinout wrong");
	AST_STRAP: assert property ($fell(srst) |=> station_address == {3'h0, $past(address_strap)})
		else $error("strap address wrong");
	AST_ADDR: assert property (wr_ok && reg_addr == PVM_OFF_SPECIAL |=> station_address == $past(reg_wdata[4:0]))
		else $error("address not written");
	AST_FIFO: assert property (wr_ok && reg_addr == PVM_OFF_EXTMODE |=> tx_fifo_depth_sel == $past(reg_wdata[10:9]))
		else $error("fifo depth not written");
	AST_IDX: assert property (wr_ok && reg_addr == PVM_OFF_ADDRPORT |=> adv_index == $past(reg_wdata[6:0]))
		else $error("index not written");
	AST_LATCH: assert property (wr_ok && reg_addr == PVM_OFF_ADDRPORT && reg_wdata[15] && reg_wdata[6:0] == adv_index && adv_index <= PVM_AP_INDEX_MAX ##1 reg_addr == PVM_OFF_DATAPORT |-> reg_rdata == $past(adv_rdata))
		else $error("latched data wrong");
endmodule
bind pvm_regs pvm_regs_sva chk (.*);
`default_nettype wire

/* File: sim/pvm_regs_tb_top.sv */
// Self-checking bench for the vendor mode register bank.
// Assumes pvm_regs and the advanced register model.
`timescale 1ns/10ps
`default_nettype none
module pvm_regs_tb_top;
	import pvm_pkg::*;
	logic clock = 1'h0, srst = 1'h1, reg_wr = 1'h0, internal_delay_strap = 1'h1;
	logic mac_clock_slow_select = 1'h0, tenbase_polarity_flag = 1'h0;
	logic auto_xover_disable = 1'h0, auto_xover_pinout = 1'h0;
	logic [4:0] reg_addr = 5'h00, station_address, function_setting;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, adv_rdata;
	logic [1:0] address_strap = 2'h2, mode_strap = 2'h1, tx_fifo_depth_sel;
	logic [6:0] adv_index;
	logic early_rxdv_en, hd_loopback_dis, crc_src_tx, pinout_x01, pinout_x23;
	logic cond_par_detect, tx_clk_delay_en, rx_clk_delay_en;
	int failures = 0, comparisons = 0;
	pvm_regs dut (.*);
	pvm_adv_model adv (.*);
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(logic [4:0] a, logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge clock);
		reg_wr = 1'h0;
	endtask
	task automatic rd(logic [4:0] a, logic [15:0] e);
		reg_addr = a;
		#1 chk($sformatf("reg %h", a), e, reg_rdata);
		@(negedge clock);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic t_reset;
		rd(PVM_OFF_SPECIAL, 16'h0002);
		chk("station", 16'h0002, {11'h0, station_address});
		rd(PVM_OFF_EXTMODE, 16'h0838);
		rd(PVM_OFF_ADDRPORT, 16'h0180);
		rd(PVM_OFF_DATAPORT, 16'h0000);
		rd(PVM_OFF_INDICATE, 16'h0300);
		rd(5'h00, 16'h0000);
		$display("reset done");
	endtask
	task automatic t_special;
		wr(PVM_OFF_SPECIAL, 16'hC09F);
		chk("flags", 16'h0007, {13'h0, early_rxdv_en, hd_loopback_dis, crc_src_tx});
		mac_clock_slow_select = 1'h1;
		rd(PVM_OFF_SPECIAL, 16'hC0DF);
		mac_clock_slow_select = 1'h0;
		wr(PVM_OFF_SPECIAL, 16'h0040);
		rd(PVM_OFF_SPECIAL, 16'h0000);
		$display("special done");
	endtask
	task automatic t_ext;
		for (int i = 0; i < 4; i++) begin
			wr(PVM_OFF_EXTMODE, {5'h1F, i[1:0], 6'h07, 3'h5});
			rd(PVM_OFF_EXTMODE, {5'h1F, i[1:0], 6'h07, 3'h5});
		end
		chk("mode", 16'h001F, {11'h0, function_setting});
		auto_xover_disable = 1'h1;
		#1 chk("pins", 16'h0005, {13'h0, pinout_x01, pinout_x23, cond_par_detect});
		auto_xover_disable = 1'h0;
		auto_xover_pinout = 1'h1;
		#1 chk("pins", 16'h0007, {13'h0, pinout_x01, pinout_x23, cond_par_detect});
		@(negedge clock);
		$display("extended done");
	endtask
	task automatic t_indirect;
		wr(PVM_OFF_ADDRPORT, 16'h0185);
		wr(PVM_OFF_ADDRPORT, 16'h8185);
		rd(PVM_OFF_DATAPORT, 16'hA505);
		rd(PVM_OFF_ADDRPORT, 16'h0185);
		wr(PVM_OFF_DATAPORT, 16'h1234);
		rd(PVM_OFF_DATAPORT, 16'hA505);
		wr(PVM_OFF_ADDRPORT, 16'h818D);
		rd(PVM_OFF_DATAPORT, 16'h0000);
		wr(PVM_OFF_ADDRPORT, 16'h018C);
		wr(PVM_OFF_ADDRPORT, 16'h818C);
		rd(PVM_OFF_DATAPORT, 16'hA50C);
		$display("indirect done");
	endtask
	task automatic t_ci;
		tenbase_polarity_flag = 1'h1;
		wr(PVM_OFF_INDICATE, 16'h0200);
		rd(PVM_OFF_INDICATE, 16'h0210);
		chk("delay", 16'h0002, {14'h0, tx_clk_delay_en, rx_clk_delay_en});
		$display("indications done");
	endtask
	initial begin
		repeat (4) @(negedge clock);
		srst = 1'h0;
		@(negedge clock);
		t_reset;
		t_special;
		t_ext;
		t_indirect;
		t_ci;
		end_of_test;
	end
	initial begin
		#20000;
		failures++;
		end_of_test;
	end
endmodule
`default_nettype wire

/* File: verilog/pvm_pkg.sv */
// Constants for the vendor mode register bank: offsets, field positions, resets.
// Assumes a management front end that presents decoded register reads and writes.
`default_nettype none
package pvm_pkg;
	localparam logic [4:0] PVM_OFF_SPECIAL = 5'h12;
	localparam logic [4:0] PVM_OFF_EXTMODE = 5'h13;
	localparam logic [4:0] PVM_OFF_ADDRPORT = 5'h14;
	localparam logic [4:0] PVM_OFF_DATAPORT = 5'h15;
	localparam logic [4:0] PVM_OFF_INDICATE = 5'h1B;
	localparam int PVM_SM_EARLY_RXDV = 15;
	localparam int PVM_SM_LOOP_DIS = 14;
	localparam int PVM_SM_CRC_SRC = 7;
	localparam int PVM_SM_MCLK = 6;
	localparam int PVM_EM_MODE_LSB = 11;
	localparam int PVM_EM_FIFO_LSB = 9;
	localparam int PVM_EM_RSV_LSB = 3;
	localparam int PVM_EM_MDI01 = 2;
	localparam int PVM_EM_MDI23 = 1;
	localparam int PVM_EM_CPD = 0;
	localparam int PVM_AP_READ = 15;
	localparam int PVM_AP_RSV_LSB = 7;
	localparam int PVM_CI_TXDLY = 9;
	localparam int PVM_CI_RXDLY = 8;
	localparam int PVM_CI_POL = 4;
	localparam logic [2:0] PVM_EM_RSV_RESET = 3'h7;
	localparam logic [1:0] PVM_EM_FIFO_RESET = 2'h0;
	localparam logic [7:0] PVM_AP_RSV_RESET = 8'h03;
	localparam logic [6:0] PVM_AP_INDEX_RESET = 7'h00;
	localparam logic [15:0] PVM_DATA_RESET = 16'h0000;
	localparam logic [6:0] PVM_AP_INDEX_MAX = 7'h0C;
endpackage
`default_nettype wire

/* File: verilog/pvm_regs.sv */
// Vendor mode register bank of a tri-speed transceiver.
// Assumes the management bus engine gives one-cycle write strobes and a read address.
`timescale 1ns/10ps
`default_nettype none
module pvm_regs
	import pvm_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic [1:0] address_strap,
	input wire logic [1:0] mode_strap,
	input wire logic internal_delay_strap,
	input wire logic mac_clock_slow_select,
	input wire logic tenbase_polarity_flag,
	input wire logic auto_xover_disable,
	input wire logic auto_xover_pinout,
	input wire logic [15:0] adv_rdata,
	output logic [6:0] adv_index,
	output logic early_rxdv_en,
	output logic hd_loopback_dis,
	output logic crc_src_tx,
	output logic [4:0] station_address,
	output logic [4:0] function_setting,
	output logic [1:0] tx_fifo_depth_sel,
	output logic pinout_x01,
	output logic pinout_x23,
	output logic cond_par_detect,
	output logic tx_clk_delay_en,
	output logic rx_clk_delay_en
);
	import pvm_pkg::*;

	logic sm_early_q, sm_early_d, sm_loop_q, sm_loop_d, sm_crc_q, sm_crc_d;
	logic [4:0] addr_q, addr_d, mode_q, mode_d;
	logic [1:0] fifo_q, fifo_d;
	logic [2:0] rsv_q, rsv_d;
	logic mdi01_q, mdi01_d, mdi23_q, mdi23_d, cpd_q, cpd_d;
	logic [7:0] aprsv_q, aprsv_d;
	logic [6:0] index_q, index_d;
	logic [15:0] data_q, data_d;
	logic txd_q, txd_d, rxd_q, rxd_d;
	logic strap_q, strap_d;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		return a == off;
	endfunction

	always_comb begin
		sm_early_d = sm_early_q;
		sm_loop_d = sm_loop_q;
		sm_crc_d = sm_crc_q;
		addr_d = addr_q;
		mode_d = mode_q;
		fifo_d = fifo_q;
		rsv_d = rsv_q;
		mdi01_d = mdi01_q;
		mdi23_d = mdi23_q;
		cpd_d = cpd_q;
		aprsv_d = aprsv_q;
		index_d = index_q;
		data_d = data_q;
		txd_d = txd_q;
		rxd_d = rxd_q;
		strap_d = 1'b0;
		if (strap_q) begin
			// Straps caught on the first cycle after reset release
			addr_d = {3'h0, address_strap};
			mode_d = {3'h0, mode_strap};
			txd_d = internal_delay_strap;
			rxd_d = internal_delay_strap;
		end else if (reg_wr) begin
			if (hit(reg_addr, PVM_OFF_SPECIAL)) begin
				sm_early_d = reg_wdata[PVM_SM_EARLY_RXDV];
				sm_loop_d = reg_wdata[PVM_SM_LOOP_DIS];
				sm_crc_d = reg_wdata[PVM_SM_CRC_SRC];
				addr_d = reg_wdata[4:0];
			end
			if (hit(reg_addr, PVM_OFF_EXTMODE)) begin
				mode_d = reg_wdata[PVM_EM_MODE_LSB +: 5];
				fifo_d = reg_wdata[PVM_EM_FIFO_LSB +: 2];
				rsv_d = reg_wdata[PVM_EM_RSV_LSB +: 3];
				mdi01_d = reg_wdata[PVM_EM_MDI01];
				mdi23_d = reg_wdata[PVM_EM_MDI23];
				cpd_d = reg_wdata[PVM_EM_CPD];
			end
			if (hit(reg_addr, PVM_OFF_ADDRPORT)) begin
				aprsv_d = reg_wdata[PVM_AP_RSV_LSB +: 8];
				index_d = reg_wdata[6:0];
				if (reg_wdata[PVM_AP_READ]) begin
					// Latch reads the index already held; select it in an earlier write
					data_d = (reg_wdata[6:0] <= PVM_AP_INDEX_MAX) ? adv_rdata : PVM_DATA_RESET;
				end
			end
			if (hit(reg_addr, PVM_OFF_INDICATE)) begin
				txd_d = reg_wdata[PVM_CI_TXDLY];
				rxd_d = reg_wdata[PVM_CI_RXDLY];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			sm_early_q <= 1'b0;
			sm_loop_q <= 1'b0;
			sm_crc_q <= 1'b0;
			addr_q <= 5'h00;
			mode_q <= 5'h00;
			fifo_q <= PVM_EM_FIFO_RESET;
			rsv_q <= PVM_EM_RSV_RESET;
			mdi01_q <= 1'b0;
			mdi23_q <= 1'b0;
			cpd_q <= 1'b0;
			aprsv_q <= PVM_AP_RSV_RESET;
			index_q <= PVM_AP_INDEX_RESET;
			data_q <= PVM_DATA_RESET;
			txd_q <= 1'b0;
			rxd_q <= 1'b0;
			strap_q <= 1'b1;
		end else begin
			sm_early_q <= sm_early_d;
			sm_loop_q <= sm_loop_d;
			sm_crc_q <= sm_crc_d;
			addr_q <= addr_d;
			mode_q <= mode_d;
			fifo_q <= fifo_d;
			rsv_q <= rsv_d;
			mdi01_q <= mdi01_d;
			mdi23_q <= mdi23_d;
			cpd_q <= cpd_d;
			aprsv_q <= aprsv_d;
			index_q <= index_d;
			data_q <= data_d;
			txd_q <= txd_d;
			rxd_q <= rxd_d;
			strap_q <= strap_d;
		end
	end

	// Read mux; the read bit always reads back zero
	always_comb begin
		reg_rdata = 16'h0000;
		unique case (reg_addr)
			PVM_OFF_SPECIAL: begin
				reg_rdata[PVM_SM_EARLY_RXDV] = sm_early_q;
				reg_rdata[PVM_SM_LOOP_DIS] = sm_loop_q;
				reg_rdata[PVM_SM_CRC_SRC] = sm_crc_q;
				reg_rdata[PVM_SM_MCLK] = mac_clock_slow_select;
				reg_rdata[4:0] = addr_q;
			end
			PVM_OFF_EXTMODE: begin
				reg_rdata = {mode_q, fifo_q, 3'h0, rsv_q, mdi01_q, mdi23_q, cpd_q};
			end
			PVM_OFF_ADDRPORT: begin
				reg_rdata = {1'b0, aprsv_q, index_q};
			end
			PVM_OFF_DATAPORT: begin
				reg_rdata = data_q;
			end
			PVM_OFF_INDICATE: begin
				reg_rdata[PVM_CI_TXDLY] = txd_q;
				reg_rdata[PVM_CI_RXDLY] = rxd_q;
				reg_rdata[PVM_CI_POL] = tenbase_polarity_flag;
			end
			default: begin
				reg_rdata = 16'h0000;
			end
		endcase
	end

	assign adv_index = index_q;
	assign early_rxdv_en = sm_early_q;
	assign hd_loopback_dis = sm_loop_q;
	assign crc_src_tx = sm_crc_q;
	assign station_address = addr_q;
	assign function_setting = mode_q;
	assign tx_fifo_depth_sel = fifo_q;
	assign pinout_x01 = auto_xover_disable ? mdi01_q : auto_xover_pinout;
	assign pinout_x23 = auto_xover_disable ? mdi23_q : auto_xover_pinout;
	assign cond_par_detect = cpd_q;
	assign tx_clk_delay_en = txd_q;
	assign rx_clk_delay_en = rxd_q;
endmodule
`default_nettype wire
